// ==== verilog/dmad_pkg.sv ====
/*
  Shared constants and types for the multiply/accumulate/divide datapath:
  operation codes, configuration bit positions, divide step numbers,
  saturation limits and register offsets.
  Assumes the instruction sequencer encodes its operations with dmad_op_t.
*/
package dmad_pkg;

  localparam int          DATA_W           = 16;
  localparam int          ACC_W            = 40;
  localparam int          PROD_W           = 33;
  localparam int          LOOP_CNT_W       = 14;
  localparam int          CFG_W            = 7;

  // Configuration bit positions
  localparam int          CFG_INT_BIT      = 0;
  localparam int          CFG_UNSIGNED_BIT = 1;
  localparam int          CFG_RND_BIT      = 2;
  localparam int          CFG_ACC_ONE_SAT_EN_BIT     = 3;
  localparam int          CFG_ACC_TWO_SAT_EN_BIT     = 4;
  localparam int          CFG_STORE_SAT_EN_BIT    = 5;
  localparam int          CFG_SAT_RANGE_SELECT_BIT   = 6;
  localparam logic [6:0]  CFG_RST          = 7'h00;

  // Divide step numbers, derived from the loop count
  localparam logic [4:0]  DIV_REPEAT_COUNT = 5'h12;
  localparam logic [4:0]  DIV_SETUP_STEP   = 5'h00;
  localparam logic [4:0]  DIV_LAST_SHIFT   = 5'h10;
  localparam logic [4:0]  DIV_QFIX_STEP    = 5'h11;
  localparam logic [4:0]  DIV_RFIX_STEP    = 5'h12;

  // Saturation limits
  localparam logic [39:0] SAT_WIDE_MAX     = 40'h7F_FFFF_FFFF;
  localparam logic [39:0] SAT_WIDE_MIN     = 40'h80_0000_0000;
  localparam logic [39:0] SAT_NARROW_MAX   = 40'h00_7FFF_FFFF;
  localparam logic [39:0] SAT_NARROW_MIN   = 40'hFF_8000_0000;
  localparam logic [15:0] STORE_MAX        = 16'h7FFF;
  localparam logic [15:0] STORE_MIN        = 16'h8000;
  localparam logic [15:0] ROUND_TIE        = 16'h8000;

  // APB register byte offsets
  localparam logic [11:0] CONFIG_OFS       = 12'h000;
  localparam logic [11:0] STATUS_OFS       = 12'h004;
  localparam logic [11:0] ACCUM_FIRST_LO_OFS      = 12'h008;
  localparam logic [11:0] ACCUM_FIRST_HI_OFS      = 12'h00C;
  localparam logic [11:0] ACCUM_SECOND_LO_OFS      = 12'h010;
  localparam logic [11:0] ACCUM_SECOND_HI_OFS      = 12'h014;
  localparam int          STAT_BUSY_BIT    = 16;

  typedef enum logic [4:0] {
    nop_op,
    clear_op,
    sq_distance_op,
    sq_distance_accum_op,
    multiply_accumulate_op,
    square_accumulate_op,
    prefetch_writeback_op,
    product_load_op,
    neg_product_load_op,
    multiply_subtract_op,
    acc_add_op,
    acc_sub_op,
    acc_neg_op,
    acc_load_op,
    data_add_op,
    core_int_product,
    frac_quotient_op,
    signed_long_quotient_op,
    unsigned_long_quotient_op,
    signed_short_quotient_op,
    unsigned_short_quotient_op
  } dmad_op_t;

endpackage

// ==== verilog/dmad_mult.sv ====
/*
  17x17 multiplier with output scaler, shared by the signal-processing
  operations and the core integer multiply.
  Assumes operands are already 16-bit words; purely combinational.
*/
`timescale 1ns/1ps

module dmad_mult
  import dmad_pkg::*;
(
  input  wire logic [DATA_W-1:0] a_i,
  input  wire logic [DATA_W-1:0] b_i,
  input  wire logic              a_signed_i,
  input  wire logic              b_signed_i,
  input  wire logic              frac_i,
  output logic      [PROD_W-1:0] prod_o
);

  logic [16:0] a_ext;
  logic [16:0] b_ext;
  logic [33:0] raw;
  logic [33:0] scaled;

  // 17th bit: sign copy for signed operands, zero otherwise
  assign a_ext  = {a_signed_i & a_i[15], a_i};
  assign b_ext  = {b_signed_i & b_i[15], b_i};
  assign raw    = 34'($signed(a_ext) * $signed(b_ext));
  // Fractional scaling drops the duplicate sign bit to give 1.31
  assign scaled = frac_i ? {raw[32:0], 1'b0} : raw;
  assign prod_o = scaled[PROD_W-1:0];

endmodule

// ==== verilog/dmad_core.sv ====
/*
  Multiply/accumulate/divide datapath with its single-instruction repeat
  counter, two 40-bit accumulators, write-back rounding and an APB slave.
  Assumes the sequencer issues operations with op_valid_i while op_ready_o
  is high, loads the repeat count at least one cycle before the repeated
  operation, and that operand inputs are synchronous to ref_clk_i.
*/
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ps

module dmad_core
  import dmad_pkg::*;
#(
  parameter int CNT_W = LOOP_CNT_W
) (
  input  wire logic              ref_clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [11:0]       paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  input  wire logic              rpt_load_i,
  input  wire logic [CNT_W-1:0]  rpt_value_i,
  input  wire logic              op_valid_i,
  input  wire dmad_op_t          op_code_i,
  input  wire logic              acc_sel_i,
  input  wire logic              suspend_i,
  output logic                   op_ready_o,
  output logic                   busy_o,
  input  wire logic [DATA_W-1:0] x_i,
  input  wire logic [DATA_W-1:0] y_i,
  input  wire logic [DATA_W-1:0] dividend_lo_i,
  input  wire logic [DATA_W-1:0] dividend_hi_i,
  input  wire logic [DATA_W-1:0] divisor_i,
  input  wire logic [5:0]        shift_i,
  input  wire logic              mul_a_signed_i,
  input  wire logic              mul_b_signed_i,
  input  wire logic              mul_byte_i,
  input  wire logic              wb_req_i,
  input  wire logic              w_restore_i,
  input  wire logic [DATA_W-1:0] quotient_restore_i,
  input  wire logic [DATA_W-1:0] remainder_restore_i,
  output logic      [DATA_W-1:0] quotient_o,
  output logic      [DATA_W-1:0] remainder_o,
  output logic      [31:0]       core_product_o,
  output logic                   wb_valid_o,
  output logic      [DATA_W-1:0] wb_data_o,
  output logic      [ACC_W-1:0]  accum_first_o,
  output logic      [ACC_W-1:0]  accum_second_o,
  output logic      [CNT_W-1:0]  loop_count_o
);

  typedef struct packed {
    logic [CFG_W-1:0]  cfg;
    logic [CNT_W-1:0]  loop_cnt;
    logic              busy;
    dmad_op_t          op;
    logic              acc_sel;
    logic              neg_q;
    logic              neg_r;
    logic [DATA_W-1:0] dvs;
    logic [DATA_W-1:0] quo;
    logic [DATA_W-1:0] rmd;
    logic [ACC_W-1:0]  acc_a;
    logic [ACC_W-1:0]  acc_b;
    logic [31:0]       prod;
    logic              wb_valid;
    logic [DATA_W-1:0] wb_data;
    logic              ack;
    logic              err;
    logic [31:0]       rdata;
  } dmad_state_t;

  dmad_state_t state_reg;
  dmad_state_t state_next;

  //////////////////////////////////////////////////////////////////////////////
  // Helper functions

  function automatic logic is_div(input dmad_op_t op);
    is_div = (op == frac_quotient_op) || (op == signed_long_quotient_op) ||
             (op == unsigned_long_quotient_op) || (op == signed_short_quotient_op) ||
             (op == unsigned_short_quotient_op);
  endfunction

  function automatic logic wb_allowed(input dmad_op_t op);
    wb_allowed = (op == clear_op) || (op == multiply_accumulate_op) ||
                 (op == prefetch_writeback_op) || (op == multiply_subtract_op);
  endfunction

  function automatic logic [40:0] sx41(input logic [39:0] v);
    sx41 = {v[39], v};
  endfunction

  // Saturate a 41-bit adder result to the selected range
  function automatic logic [39:0] sat_acc(input logic [40:0] v, input logic en,
                                          input logic wide);
    logic ovf39;
    logic ovf31;
    ovf39 = v[40] ^ v[39];
    ovf31 = (v[40:31] != 10'h000) && (v[40:31] != 10'h3FF);
    sat_acc = v[39:0];
    if (en && wide && ovf39) begin
      sat_acc = v[40] ? SAT_WIDE_MIN : SAT_WIDE_MAX;
    end else if (en && !wide && ovf31) begin
      sat_acc = v[40] ? SAT_NARROW_MIN : SAT_NARROW_MAX;
    end
  endfunction

  // Rounded high word of an accumulator with optional store saturation
  function automatic logic [15:0] store_word(input logic [39:0] acc, input logic conv,
                                             input logic sat);
    logic        inc;
    logic [15:0] hi;
    inc = acc[15] & (!conv | (acc[15:0] != ROUND_TIE) | acc[16]);
    hi  = acc[31:16] + {15'h0000, inc};
    store_word = hi;
    if (sat && !acc[39] && ((acc[38:31] != 8'h00) || hi[15])) begin
      store_word = STORE_MAX;
    end else if (sat && acc[39] && ((acc[38:31] != 8'hFF) || !hi[15])) begin
      store_word = STORE_MIN;
    end
  endfunction

  // Positive amount shifts right (max 15), negative shifts left (max 16)
  function automatic logic [39:0] barrel(input logic [39:0] v, input logic [5:0] sh);
    logic [5:0] amt;
    amt = 6'(-sh);
    if (sh[5]) begin
      barrel = v << ((amt > 6'h10) ? 5'h10 : amt[4:0]);
    end else begin
      barrel = $signed(v) >>> ((sh[4:0] > 5'h0F) ? 5'h0F : sh[4:0]);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Issue, repeat and operand selection

  logic              start;
  logic              exec;
  dmad_op_t          cur_op;
  logic              cur_sel;
  logic [4:0]        step;
  logic [DATA_W-1:0] diff;
  logic [DATA_W-1:0] mul_a;
  logic [DATA_W-1:0] mul_b;
  logic              mul_as;
  logic              mul_bs;
  logic              mul_frac;
  logic [PROD_W-1:0] prod33;
  logic [ACC_W-1:0]  prod40;
  logic [ACC_W-1:0]  tgt;
  logic [ACC_W-1:0]  oth;
  logic [ACC_W-1:0]  shifted;

  assign start   = op_valid_i && !state_reg.busy;
  assign exec    = start || (state_reg.busy && !suspend_i);
  assign cur_op  = state_reg.busy ? state_reg.op : op_code_i;
  assign cur_sel = state_reg.busy ? state_reg.acc_sel : acc_sel_i;
  // Step number follows the loop count, so restored registers resume cleanly
  assign step    = (state_reg.loop_cnt > CNT_W'(DIV_REPEAT_COUNT)) ? DIV_SETUP_STEP :
                   5'(CNT_W'(DIV_REPEAT_COUNT) - state_reg.loop_cnt);
  assign diff    = x_i - y_i;
  assign tgt     = cur_sel ? state_reg.acc_b : state_reg.acc_a;
  assign oth     = cur_sel ? state_reg.acc_a : state_reg.acc_b;
  assign shifted = barrel({{8{x_i[15]}}, x_i, 16'h0000}, shift_i);
  assign prod40  = {{(ACC_W-PROD_W){prod33[PROD_W-1]}}, prod33};

  always_comb begin
    mul_a    = x_i;
    mul_b    = y_i;
    mul_as   = !state_reg.cfg[CFG_UNSIGNED_BIT];
    mul_bs   = !state_reg.cfg[CFG_UNSIGNED_BIT];
    mul_frac = !state_reg.cfg[CFG_INT_BIT];
    if (cur_op == sq_distance_op || cur_op == sq_distance_accum_op) begin
      mul_a  = diff;
      mul_b  = diff;
      mul_as = 1'b1;
      mul_bs = 1'b1;
    end else if (cur_op == square_accumulate_op) begin
      mul_b  = x_i;
    end else if (cur_op == core_int_product) begin
      mul_as   = mul_a_signed_i;
      mul_bs   = mul_b_signed_i;
      mul_frac = 1'b0;
      if (mul_byte_i) begin
        mul_a = {{8{mul_a_signed_i & x_i[7]}}, x_i[7:0]};
        mul_b = {{8{mul_b_signed_i & y_i[7]}}, y_i[7:0]};
      end
    end
  end

  dmad_mult u_mult (
    .a_i        (mul_a),
    .b_i        (mul_b),
    .a_signed_i (mul_as),
    .b_signed_i (mul_bs),
    .frac_i     (mul_frac),
    .prod_o     (prod33)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    logic        sgn;
    logic [31:0] dd;
    logic [31:0] dd_mag;
    logic [16:0] t17;
    logic [40:0] sum;
    logic        sat_en;
    sgn        = 1'b0;
    dd         = 32'h0000_0000;
    dd_mag     = 32'h0000_0000;
    t17        = 17'h0_0000;
    sum        = sx41(tgt);
    sat_en     = cur_sel ? state_reg.cfg[CFG_ACC_TWO_SAT_EN_BIT] : state_reg.cfg[CFG_ACC_ONE_SAT_EN_BIT];
    state_next = state_reg;
    state_next.wb_valid = 1'b0;

    if (rpt_load_i && !state_reg.busy) begin
      state_next.loop_cnt = rpt_value_i;
    end

    if (exec) begin
      // Repeat runs the operation count+1 times; a divide never reloads it
      if (state_reg.loop_cnt == '0) begin
        state_next.busy = 1'b0;
      end else begin
        state_next.busy     = 1'b1;
        state_next.loop_cnt = state_reg.loop_cnt - 1'b1;
      end
      if (start) begin
        state_next.op      = op_code_i;
        state_next.acc_sel = acc_sel_i;
      end
    end

    if (exec && is_div(cur_op)) begin
      if (step == DIV_SETUP_STEP) begin
        sgn = (cur_op != unsigned_long_quotient_op) && (cur_op != unsigned_short_quotient_op);
        case (cur_op)
          signed_long_quotient_op, unsigned_long_quotient_op: begin
            dd = {dividend_hi_i, dividend_lo_i};
          end
          frac_quotient_op: begin
            dd = {dividend_lo_i[15], dividend_lo_i, 15'h0000};
          end
          signed_short_quotient_op: begin
            dd = {{16{dividend_lo_i[15]}}, dividend_lo_i};
          end
          default: begin
            dd = {16'h0000, dividend_lo_i};
          end
        endcase
        dd_mag           = (sgn && dd[31]) ? 32'(-dd) : dd;
        state_next.rmd   = dd_mag[31:16];
        state_next.quo   = dd_mag[15:0];
        state_next.dvs   = (sgn && divisor_i[15]) ? 16'(-divisor_i) : divisor_i;
        state_next.neg_q = sgn && (dd[31] ^ divisor_i[15]);
        state_next.neg_r = sgn && dd[31];
      end else if (step <= DIV_LAST_SHIFT) begin
        // Restoring step on magnitudes, one quotient bit per cycle
        t17 = {state_reg.rmd, state_reg.quo[15]};
        if (t17 >= {1'b0, state_reg.dvs}) begin
          t17            = t17 - {1'b0, state_reg.dvs};
          state_next.quo = {state_reg.quo[14:0], 1'b1};
        end else begin
          state_next.quo = {state_reg.quo[14:0], 1'b0};
        end
        state_next.rmd = t17[15:0];
      end else if (step == DIV_QFIX_STEP) begin
        state_next.quo = state_reg.neg_q ? 16'(-state_reg.quo) : state_reg.quo;
      end else begin
        state_next.rmd = state_reg.neg_r ? 16'(-state_reg.rmd) : state_reg.rmd;
      end
    end else if (w_restore_i) begin
      state_next.quo = quotient_restore_i;
      state_next.rmd = remainder_restore_i;
    end

    if (exec && !is_div(cur_op)) begin
      case (cur_op)
        clear_op:               sum = 41'h000_0000_0000;
        sq_distance_op:         sum = sx41(prod40);
        sq_distance_accum_op:   sum = sx41(tgt) + sx41(prod40);
        multiply_accumulate_op: sum = sx41(tgt) + sx41(prod40);
        square_accumulate_op:   sum = sx41(tgt) + sx41(prod40);
        product_load_op:        sum = sx41(prod40);
        neg_product_load_op:    sum = 41'h000_0000_0000 - sx41(prod40);
        multiply_subtract_op:   sum = sx41(tgt) - sx41(prod40);
        acc_add_op:             sum = sx41(tgt) + sx41(oth);
        acc_sub_op:             sum = sx41(tgt) - sx41(oth);
        acc_neg_op:             sum = 41'h000_0000_0000 - sx41(tgt);
        acc_load_op:            sum = sx41(shifted);
        data_add_op:            sum = sx41(tgt) + sx41(shifted);
        default:                sum = sx41(tgt);
      endcase
      if (cur_op != core_int_product && cur_op != prefetch_writeback_op &&
          cur_op != nop_op) begin
        if (cur_sel) begin
          state_next.acc_b = sat_acc(sum, sat_en, state_reg.cfg[CFG_SAT_RANGE_SELECT_BIT]);
        end else begin
          state_next.acc_a = sat_acc(sum, sat_en, state_reg.cfg[CFG_SAT_RANGE_SELECT_BIT]);
        end
      end
      if (cur_op == core_int_product) begin
        state_next.prod = mul_byte_i ? {16'h0000, prod33[15:0]} : prod33[31:0];
      end
      if (wb_req_i && wb_allowed(cur_op)) begin
        state_next.wb_valid = 1'b1;
        state_next.wb_data  = store_word(oth, state_reg.cfg[CFG_RND_BIT],
                                         state_reg.cfg[CFG_STORE_SAT_EN_BIT]);
      end
    end

    // APB: read data captured in first access cycle, answered in the second
    if (psel_i && penable_i && !state_reg.ack) begin
      state_next.ack   = 1'b1;
      state_next.err   = 1'b0;
      state_next.rdata = 32'h0000_0000;
      case (paddr_i)
        CONFIG_OFS:  state_next.rdata = {25'h000_0000, state_reg.cfg};
        STATUS_OFS:  state_next.rdata = 32'({state_reg.busy, 16'(state_reg.loop_cnt)});
        ACCUM_FIRST_LO_OFS: state_next.rdata = state_reg.acc_a[31:0];
        ACCUM_FIRST_HI_OFS: state_next.rdata = {{24{state_reg.acc_a[39]}}, state_reg.acc_a[39:32]};
        ACCUM_SECOND_LO_OFS: state_next.rdata = state_reg.acc_b[31:0];
        ACCUM_SECOND_HI_OFS: state_next.rdata = {{24{state_reg.acc_b[39]}}, state_reg.acc_b[39:32]};
        default:     state_next.err   = 1'b1;
      endcase
    end else if (state_reg.ack) begin
      state_next.ack = 1'b0;
      if (pwrite_i && paddr_i == CONFIG_OFS) begin
        state_next.cfg = pwdata_i[CFG_W-1:0];
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg     <= '0;
      state_reg.cfg <= CFG_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign prdata_o       = state_reg.rdata;
  assign pready_o       = state_reg.ack;
  assign pslverr_o      = state_reg.ack && state_reg.err;
  assign op_ready_o     = !state_reg.busy;
  assign busy_o         = state_reg.busy;
  assign quotient_o     = state_reg.quo;
  assign remainder_o    = state_reg.rmd;
  assign core_product_o = state_reg.prod;
  assign wb_valid_o     = state_reg.wb_valid;
  assign wb_data_o      = state_reg.wb_data;
  assign accum_first_o  = state_reg.acc_a;
  assign accum_second_o = state_reg.acc_b;
  assign loop_count_o   = state_reg.loop_cnt;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  cnt_decrement_a: assert property (exec && state_reg.loop_cnt != '0 |=>
    busy_o && loop_count_o == $past(state_reg.loop_cnt) - 1'b1)
    else $error("repeat count did not step down");
  last_pass_a: assert property (exec && state_reg.loop_cnt == '0 |=> !busy_o)
    else $error("repeat did not end after final pass");
  no_reload_a: assert property (busy_o |=> loop_count_o <= $past(state_reg.loop_cnt))
    else $error("loop count grew while busy");
  short_extend_a: assert property (start && step == DIV_SETUP_STEP &&
    (op_code_i == signed_short_quotient_op || op_code_i == unsigned_short_quotient_op)
    |=> remainder_o == 16'h0000)
    else $error("short divide high word not extended");
  qfix_a: assert property (exec && is_div(cur_op) && step == DIV_QFIX_STEP &&
    state_reg.neg_q |=> quotient_o == 16'($past(-state_reg.quo)))
    else $error("quotient sign not applied");
  suspend_hold_a: assert property (busy_o && suspend_i && !w_restore_i |=>
    $stable(quotient_o) && $stable(remainder_o) && $stable(loop_count_o))
    else $error("suspended divide changed state");
  issue_gate_a: assert property (busy_o |-> !op_ready_o)
    else $error("new op accepted while busy");
  wb_gate_a: assert property (wb_valid_o |-> $past(exec && wb_req_i && wb_allowed(cur_op)))
    else $error("write-back from disallowed op");
  negate_acc_a: assert property (exec && cur_op == acc_neg_op && !cur_sel &&
    !state_reg.cfg[CFG_ACC_ONE_SAT_EN_BIT] |=> accum_first_o == 40'($past(-state_reg.acc_a)))
    else $error("accumulator negate wrong");
  word_product_a: assert property (exec && cur_op == core_int_product && !mul_byte_i &&
    mul_a_signed_i && mul_b_signed_i |=>
    $signed(core_product_o) == $past($signed(x_i)) * $past($signed(y_i)))
    else $error("signed word multiply wrong");
  apb_answer_a: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("APB answer late");

  div_done_c: cover property (exec && is_div(cur_op) && step == DIV_RFIX_STEP);
  div_suspend_c: cover property (busy_o && is_div(state_reg.op) && suspend_i);
  wb_c: cover property (wb_valid_o);
  sat_c: cover property (exec && cur_op == multiply_accumulate_op && state_reg.cfg[CFG_ACC_ONE_SAT_EN_BIT]);

endmodule

// ==== bench/dmad_seq_model.sv ====
/*
  Sequencer model: loads the repeat count, then issues one operation.
  Assumes the caller waits for the datapath to go idle before each issue.
*/
`timescale 1ns/1ps
module dmad_seq_model
  import dmad_pkg::*;
(
  input  wire logic   ref_clk_i,
  input  wire logic   op_ready_i,
  output logic        rpt_load_o,
  output logic [13:0] rpt_value_o,
  output logic        op_valid_o,
  output dmad_op_t    op_code_o
);
  initial begin
    rpt_load_o = 1'b0;
    rpt_value_o = 14'h0000;
    op_valid_o = 1'b0;
    op_code_o = nop_op;
  end
  // Count always loaded a cycle ahead; divides get 18 so they never run alone
  task automatic issue(input dmad_op_t op, input logic [13:0] cnt);
    @(posedge ref_clk_i);
    rpt_load_o <= 1'b1;
    rpt_value_o <= cnt;
    @(posedge ref_clk_i);
    rpt_load_o <= 1'b0;
    op_valid_o <= 1'b1;
    op_code_o <= op;
    do @(posedge ref_clk_i); while (op_ready_i !== 1'b1);
    op_valid_o <= 1'b0;
  endtask
endmodule

// ==== bench/testbench.sv ====
/*
  Self-checking bench: APB register accesses, divides, multiplies.
  Assumes one clock of 100 MHz and the designer's one-wait-state APB slave.
*/
`timescale 1ns/1ps
module testbench;
  import dmad_pkg::*;
  logic clk, rst, psel, pen, pwr, pready, perr, busy, rdy, ld, ov, wbv, sa, sb, mb, wbr;
  logic pe, susp, wrs;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, prod, r, sv;
  logic [13:0] rv, lc;
  logic [15:0] x, y, dlo, dhi, dv, q, rem, wbd, qrs, rrs;
  logic [39:0] acc1, acc2;
  dmad_op_t op;
  int miscompares = 0, tests_run = 0, cycles = 0, n, w;
  dmad_seq_model i_dmad_seq_model(.ref_clk_i(clk), .op_ready_i(rdy), .rpt_load_o(ld),
    .rpt_value_o(rv), .op_valid_o(ov), .op_code_o(op));
  dmad_core i_dmad_core(.ref_clk_i(clk), .sys_rst_i(rst), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(perr), .rpt_load_i(ld), .rpt_value_i(rv), .op_valid_i(ov), .op_code_i(op),
    .acc_sel_i(sb), .suspend_i(susp), .op_ready_o(rdy), .busy_o(busy), .x_i(x), .y_i(y),
    .dividend_lo_i(dlo), .dividend_hi_i(dhi), .divisor_i(dv), .shift_i(6'h00),
    .mul_a_signed_i(sa), .mul_b_signed_i(sa), .mul_byte_i(mb), .wb_req_i(wbr),
    .w_restore_i(wrs), .quotient_restore_i(qrs), .remainder_restore_i(rrs),
    .quotient_o(q), .remainder_o(rem), .core_product_o(prod), .wb_valid_o(wbv),
    .wb_data_o(wbd), .accum_first_o(acc1), .accum_second_o(acc2), .loop_count_o(lc));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, pen, pwr, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    pe = perr;
    {psel, pen} <= 2'b00;
  endtask
  // Busy and write-back counted from the issue edge on, long enough for a divide
  task automatic run(input dmad_op_t o, input logic [13:0] c);
    i_dmad_seq_model.issue(o, c);
    n = 0;
    w = 0;
    repeat (24) begin
      #1 if (busy === 1'b1) n++;
      if (wbv === 1'b1) w++;
      @(posedge clk);
    end
  endtask
  task automatic dv_case(input dmad_op_t o, input logic [47:0] d, input logic [31:0] e);
    {dhi, dlo, dv} <= d;
    run(o, 14'h0012);
    chk(n, 40'h12);
    chk({q, rem}, e);
  endtask
  task automatic finish_test();
    $display("compares %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      finish_test();
    end
  end
  initial begin
    {rst, psel, pen, pwr, paddr, pwdata, x, y, dlo, dhi, dv, sa, sb, mb, wbr} = '0;
    {pe, susp, wrs, qrs, rrs} = '0;
    rst = 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    apb(1'b1, CONFIG_OFS, 32'h0000_0041);
    apb(1'b0, CONFIG_OFS, 32'h0);
    chk(r, 32'h0000_0041);
    apb(1'b0, 12'h0FC, 32'h0);
    chk({pe, r}, 33'h1_0000_0000);
    dv_case(signed_long_quotient_op, 48'h0001_86A0_FFF9, 32'hC833_0005);
    dv_case(unsigned_long_quotient_op, 48'h0001_0000_0003, 32'h5555_0001);
    dv_case(signed_short_quotient_op, 48'h1234_FFF9_0002, 32'hFFFD_FFFF);
    dv_case(unsigned_short_quotient_op, 48'h1234_FFF9_0002, 32'h7FFC_0001);
    dv_case(frac_quotient_op, 48'h0000_2000_4000, 32'h4000_0000);
    // Divide paused after six passes, results clobbered and put back, then resumed
    {dhi, dlo, dv} <= 48'h0001_86A0_FFF9;
    i_dmad_seq_model.issue(signed_long_quotient_op, 14'h0012);
    repeat (5) @(posedge clk);
    susp <= 1'b1;
    @(posedge clk);
    sv = {q, rem};
    chk(lc, 40'h0C);
    {wrs, qrs, rrs} <= {1'b1, 32'h0000_0000};
    @(posedge clk);
    {qrs, rrs} <= sv;
    @(posedge clk);
    chk({q, rem}, 40'h0);
    {wrs, susp} <= 2'b00;
    repeat (20) @(posedge clk);
    chk({q, rem}, 40'hC833_0005);
    {x, y, sa} <= {16'h0003, 16'hFFFC, 1'b1};
    run(product_load_op, 14'h0000);
    chk(acc1, 40'hFF_FFFF_FFF4);
    run(acc_neg_op, 14'h0000);
    chk(acc1, 40'h00_0000_000C);
    run(core_int_product, 14'h0000);
    chk(prod, 32'hFFFF_FFF4);
    mb <= 1'b1;
    run(core_int_product, 14'h0000);
    chk(prod, 32'h0000_FFF4);
    apb(1'b1, CONFIG_OFS, 32'h0);
    {x, y, sb} <= {16'h4000, 16'h4000, 1'b1};
    run(product_load_op, 14'h0000);
    chk(acc2, 40'h00_2000_0000);
    apb(1'b0, ACCUM_SECOND_LO_OFS, 32'h0);
    chk(r, 32'h2000_0000);
    {sb, wbr} <= 2'b01;
    run(multiply_accumulate_op, 14'h0000);
    chk(w, 40'h1);
    chk(wbd, 40'h2000);
    chk(acc1, 40'h00_2000_000C);
    run(product_load_op, 14'h0000);
    chk(w, 40'h0);
    finish_test();
  end
endmodule
